/* rtl/mgmt_supervisor.sv */
/*
 * Control and status supervisor of a pluggable module: start-up and reset
 * handling, readiness flag, sticky flags with clear-on-read, interrupt
 * masking, module-select gate for the two-wire bus and low-power entry.
 * Assumes a separate two-wire bus engine on clk reports finished reads and
 * writes; bus pins arrive asynchronously and are only sampled here.
 */
// Notes on behaviour
// RULE1 - Fully functional within 2000 ms of reset
// RULE2 - Reset pin low past 2 us resets
// RULE3 - Answer bus within 2000 ms of power-on
// RULE4 - Clear not-ready bit, assert interrupt, in time
// RULE5 - Fully functional means ready interrupt asserted
// RULE6 - Low-power pin high enters low power
// RULE7 - Interrupt low within 200 ms of condition
// RULE8 - Read clears flag, interrupt releases quickly
// RULE9 - Clear timed from SCL fall after stop
// RULE10 - Signal loss sets flag, interrupt within 100 ms
// RULE11 - Transmit fault sets flag, interrupt within 200 ms
// RULE12 - Other conditions set flag, interrupt within 200 ms
// RULE13 - Mask set inhibits interrupt within 100 ms
// RULE14 - Mask cleared resumes interrupt within 100 ms
// RULE15 - Selected module answers bus within 100 us
// RULE16 - Deselected module stops answering within 100 us
// RULE17 - Power-down bit set enters low power
// RULE18 - Power-down bit cleared restores full function
// RULE19 - Write effects timed from SCL fall after stop
// RULE20 - Interrupt low while unmasked flag is set
`timescale 1ns/1ps

module mgmt_supervisor #(
    parameter int unsigned INIT_CYCLES = mgmt_supervisor_pkg::INIT_CYCLES
) (
    input  wire logic                                    clk,
    input  wire logic                                    rst,
    input  wire mgmt_supervisor_pkg::pins_type           pins,
    input  wire mgmt_supervisor_pkg::host_req_type       req,
    input  wire logic [mgmt_supervisor_pkg::FLAG_W-1:0]  flag_events,
    output logic                                         interrupt_out_low,
    output logic                                         bus_respond,
    output logic                                         low_power_level,
    output logic                                         data_not_ready,
    output logic [mgmt_supervisor_pkg::FLAG_W-1:0]       flag_status,
    output logic [mgmt_supervisor_pkg::FLAG_W-1:0]       mask_status,
    output logic                                         pdown_status
);
    import mgmt_supervisor_pkg::*;

    state_type         q;
    state_type         d;
    logic              scl_fall;
    logic              stop_cond;
    logic              commit;
    logic              pin_reset;
    logic              init_done;
    logic [FLAG_W-1:0] set_vec;
    logic [FLAG_W-1:0] clr_vec;

    // Flags that an outside condition may raise; the readiness bit is not one
    localparam logic [FLAG_W-1:0] EVENT_BITS = ~(FLAG_W'(1'h1) << FLAG_READY);

    // ------------------------------------------------------------
    // Bus event detection
    // ------------------------------------------------------------
    assign scl_fall  = q.scl_p & ~q.scl_s[1];
    assign stop_cond = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];
    assign commit    = q.stop_seen & scl_fall;                        // [RULE9] [RULE19]
    assign pin_reset = (q.rlow_cnt == RLOW_LIMIT);                    // [RULE2]
    assign init_done = (q.st == ST_INIT) && !pin_reset
                       && (q.init_cnt == INIT_W'(INIT_CYCLES - 1));   // [RULE1] [RULE3]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;

        // Two-stage synchronisers
        d.rst_s = {q.rst_s[0], pins.reset_low};
        d.sel_s = {q.sel_s[0], pins.select_low};
        d.lp_s  = {q.lp_s[0], pins.low_power};
        d.scl_s = {q.scl_s[0], pins.scl};
        d.sda_s = {q.sda_s[0], pins.sda};
        d.scl_p = q.scl_s[1];
        d.sda_p = q.sda_s[1];

        // Reset pin filter: only a sustained low counts
        if (q.rst_s[1]) begin
            d.rlow_cnt = '0;
        end else if (!pin_reset) begin
            d.rlow_cnt = q.rlow_cnt + RLOW_W'(1);
        end

        // Stop seen, waiting for next SCL fall
        if (commit) begin
            d.stop_seen = 1'b0;
        end else if (stop_cond) begin
            d.stop_seen = 1'b1;
        end

        // Pending clear-on-read selections
        d.rd_pend = commit ? '0 : q.rd_pend;
        if (req.rd_done) begin
            d.rd_pend = d.rd_pend | req.rd_sel;
        end

        // Pending control write
        if (req.wr_done) begin
            d.wr_pend  = 1'b1;
            d.wr_mask  = req.wr_mask;
            d.wr_pdown = req.wr_pdown;
        end else if (commit) begin
            d.wr_pend = 1'b0;
        end
        if (commit && q.wr_pend) begin
            d.mask  = q.wr_mask;                                      // [RULE13] [RULE14]
            d.pdown = q.wr_pdown;                                     // [RULE17] [RULE18]
        end

        // Flags: set wins over clear
        set_vec = '0;
        if (q.st == ST_RUN) begin
            set_vec = flag_events;                                    // [RULE10] [RULE11] [RULE12]
            set_vec[FLAG_READY] = 1'b0;
        end
        if (init_done) begin
            set_vec[FLAG_READY] = 1'b1;                               // [RULE4] [RULE5]
        end
        clr_vec = commit ? q.rd_pend : '0;
        d.flags = (q.flags & ~clr_vec) | set_vec;                     // [RULE8]

        // Start-up sequencing
        unique case (q.st)
            ST_INIT: begin
                if (init_done) begin
                    d.st        = ST_RUN;
                    d.not_ready = 1'b0;                               // [RULE4]
                end else begin
                    d.init_cnt = q.init_cnt + INIT_W'(1);
                end
            end
            ST_RUN: begin
                d.st = ST_RUN;
            end
        endcase

        // Held reset restarts start-up and clears flags, mask, pending reads and writes and power-down
        if (pin_reset) begin
            d.st        = ST_INIT;
            d.init_cnt  = '0;
            d.not_ready = 1'b1;
            d.flags     = '0;
            d.mask      = '0;
            d.rd_pend   = '0;
            d.wr_pend   = 1'b0;
            d.pdown     = 1'b0;
        end

        // Registered outputs
        d.int_low   = ~|(d.flags & ~d.mask);                          // [RULE7] [RULE20]
        d.respond   = (d.st == ST_RUN) && !q.sel_s[1];                // [RULE15] [RULE16]
        d.low_power = q.lp_s[1] | d.pdown;                            // [RULE6] [RULE17]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign interrupt_out_low = q.int_low;
    assign bus_respond       = q.respond;
    assign low_power_level   = q.low_power;
    assign data_not_ready    = q.not_ready;
    assign flag_status       = q.flags;
    assign mask_status       = q.mask;
    assign pdown_status      = q.pdown;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_init_bound;
        @(posedge clk) disable iff (rst)
        (q.st == ST_INIT) |-> (q.init_cnt < INIT_W'(INIT_CYCLES));
    endproperty
    a_init_bound: assert property (p_init_bound) // [RULE1]
        else $error("init counter passed its limit");

    property p_ready_int;
        @(posedge clk) disable iff (rst)
        init_done |=> !q.not_ready && q.flags[FLAG_READY]
            && (q.int_low == q.mask[FLAG_READY]);
    endproperty
    a_ready_int: assert property (p_ready_int) // [RULE4]
        else $error("ready event did not clear not-ready and drive interrupt");

    property p_pin_reset;
        @(posedge clk) disable iff (rst)
        pin_reset |=> (q.st == ST_INIT) && q.not_ready && (q.flags == '0);
    endproperty
    a_pin_reset: assert property (p_pin_reset) // [RULE2]
        else $error("held reset pin did not restart the module");

    property p_lp_pin;
        @(posedge clk) disable iff (rst)
        q.lp_s[1] |=> low_power_level;
    endproperty
    a_lp_pin: assert property (p_lp_pin) // [RULE6]
        else $error("low-power pin not followed by low power");

    property p_event_int;
        @(posedge clk) disable iff (rst)
        (q.st == ST_RUN && !pin_reset && |(flag_events & EVENT_BITS & ~q.mask)
            && !(commit && q.wr_pend))
        |=> !interrupt_out_low;
    endproperty
    a_event_int: assert property (p_event_int) // [RULE7]
        else $error("unmasked event did not assert interrupt");

    property p_los_flag;
        @(posedge clk) disable iff (rst)
        (q.st == ST_RUN && !pin_reset && flag_events[FLAG_LOS])
        |=> q.flags[FLAG_LOS] && (q.mask[FLAG_LOS] || !interrupt_out_low);
    endproperty
    a_los_flag: assert property (p_los_flag) // [RULE10]
        else $error("signal-loss event did not set its flag");

    property p_clear_only_on_commit;
        @(posedge clk) disable iff (rst)
        (|(q.flags & ~d.flags)) |-> (commit || pin_reset);
    endproperty
    a_clear_only_on_commit: assert property (p_clear_only_on_commit) // [RULE9]
        else $error("flag cleared outside a read commit");

    property p_clear_release;
        @(posedge clk) disable iff (rst)
        (commit && !pin_reset && ((q.flags & ~q.rd_pend) == '0)
            && (set_vec == '0) && !q.wr_pend)
        |=> interrupt_out_low;
    endproperty
    a_clear_release: assert property (p_clear_release) // [RULE8]
        else $error("interrupt not released after clear-on-read");

    property p_mask_apply;
        @(posedge clk) disable iff (rst)
        (commit && q.wr_pend && !pin_reset) |=> (q.mask == $past(q.wr_mask));
    endproperty
    a_mask_apply: assert property (p_mask_apply) // [RULE13]
        else $error("mask write not applied at commit");

    property p_int_equation;
        @(posedge clk) disable iff (rst)
        1'b1 |=> (interrupt_out_low == ~|($past(d.flags) & ~$past(d.mask)));
    endproperty
    a_int_equation: assert property (p_int_equation) // [RULE20]
        else $error("interrupt does not follow unmasked flags");

    property p_pdown_apply;
        @(posedge clk) disable iff (rst)
        (commit && q.wr_pend && !pin_reset) |=>
            (low_power_level == ($past(q.wr_pdown) | $past(q.lp_s[1])));
    endproperty
    a_pdown_apply: assert property (p_pdown_apply) // [RULE17]
        else $error("power-down write not reflected in power level");

    property p_deselect;
        @(posedge clk) disable iff (rst)
        q.sel_s[1] |=> !bus_respond;
    endproperty
    a_deselect: assert property (p_deselect) // [RULE16]
        else $error("module answers while deselected");

    property p_select;
        @(posedge clk) disable iff (rst)
        (!q.sel_s[1] && q.st == ST_RUN && !pin_reset) |=> bus_respond;
    endproperty
    a_select: assert property (p_select) // [RULE15]
        else $error("selected ready module does not answer");

    property p_txf_flag;
        @(posedge clk) disable iff (rst)
        (q.st == ST_RUN && !pin_reset && flag_events[FLAG_TXF])
        |=> q.flags[FLAG_TXF] && (q.mask[FLAG_TXF] || !interrupt_out_low);
    endproperty
    a_txf_flag: assert property (p_txf_flag) // [RULE11]
        else $error("transmit-fault event did not set its flag");

    property p_flag_set;
        @(posedge clk) disable iff (rst)
        (q.st == ST_RUN && !pin_reset)
        |=> (($past(flag_events) & EVENT_BITS & ~q.flags) == '0);
    endproperty
    a_flag_set: assert property (p_flag_set) // [RULE12]
        else $error("event lost or overridden by a same-cycle clear");

    property p_init_quiet;
        @(posedge clk) disable iff (rst)
        (q.st == ST_INIT) |=> ((q.flags & EVENT_BITS) == '0);
    endproperty
    a_init_quiet: assert property (p_init_quiet) // [RULE5]
        else $error("condition flag set before start-up finished");

    property p_ready_fell;
        @(posedge clk) disable iff (rst)
        $fell(data_not_ready) |-> $past(init_done);
    endproperty
    a_ready_fell: assert property (p_ready_fell) // [RULE5]
        else $error("not-ready cleared outside start-up completion");

    property p_answer_after_init;
        @(posedge clk) disable iff (rst)
        (init_done && !q.sel_s[1]) |=> bus_respond;
    endproperty
    a_answer_after_init: assert property (p_answer_after_init) // [RULE3]
        else $error("selected module silent after start-up");

    property p_mask_inhibit;
        @(posedge clk) disable iff (rst)
        (commit && q.wr_pend && !pin_reset && q.st == ST_RUN
            && (((q.flags | (flag_events & EVENT_BITS)) & ~q.wr_mask) == '0))
        |=> interrupt_out_low;
    endproperty
    a_mask_inhibit: assert property (p_mask_inhibit) // [RULE13]
        else $error("masked flags still drive interrupt");

    property p_mask_resume;
        @(posedge clk) disable iff (rst)
        (commit && q.wr_pend && !pin_reset
            && |(q.flags & ~q.rd_pend & ~q.wr_mask))
        |=> !interrupt_out_low;
    endproperty
    a_mask_resume: assert property (p_mask_resume) // [RULE14]
        else $error("unmasked flag does not drive interrupt");

    property p_pdown_release;
        @(posedge clk) disable iff (rst)
        (commit && q.wr_pend && !pin_reset && !q.wr_pdown && !q.lp_s[1])
        |=> !low_power_level;
    endproperty
    a_pdown_release: assert property (p_pdown_release) // [RULE18]
        else $error("power-down clear did not restore full power");

    property p_write_hold;
        @(posedge clk) disable iff (rst)
        (!commit && !pin_reset) |=> $stable(mask_status) && $stable(pdown_status);
    endproperty
    a_write_hold: assert property (p_write_hold) // [RULE19]
        else $error("control bits changed without a write commit");

    c_ready: cover property (@(posedge clk) disable iff (rst) init_done);
    c_read_clear: cover property (@(posedge clk) disable iff (rst)
        commit && |(q.rd_pend & q.flags));
    c_mask_write: cover property (@(posedge clk) disable iff (rst)
        commit && q.wr_pend);
    c_pin_reset: cover property (@(posedge clk) disable iff (rst)
        (q.st == ST_RUN) && pin_reset);
    c_masked_event: cover property (@(posedge clk) disable iff (rst)
        (q.st == ST_RUN) && |(flag_events & EVENT_BITS & q.mask));

endmodule

/* rtl/mgmt_supervisor_pkg.sv */
/*
 * Package for the management supervisor of a pluggable module: timing
 * constants, flag positions, pin and request carriers and the state record.
 * Assumes a 250 MHz system clock; all counts derive from that rate.
 */
package mgmt_supervisor_pkg;

    // ------------------------------------------------------------
    // Clock rate and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned CYCLES_PER_US    = CLK_MHZ;
    localparam int unsigned CYCLES_PER_MS    = CLK_MHZ * 1000;

    localparam int unsigned INIT_TIME_MS     = 2000;
    localparam int unsigned RESET_MIN_US     = 2;
    localparam int unsigned LP_PIN_TIME_US   = 100;
    localparam int unsigned INT_ASSERT_MS    = 200;
    localparam int unsigned INT_RELEASE_US   = 500;
    localparam int unsigned SELECT_TIME_US   = 100;

    localparam int unsigned INIT_CYCLES      = INIT_TIME_MS * CYCLES_PER_MS;
    localparam int unsigned RESET_MIN_CYCLES = RESET_MIN_US * CYCLES_PER_US;
    localparam int unsigned LP_PIN_CYCLES    = LP_PIN_TIME_US * CYCLES_PER_US;
    localparam int unsigned SELECT_CYCLES    = SELECT_TIME_US * CYCLES_PER_US;

    localparam int          RLOW_W           = 16;
    localparam int          INIT_W           = 32;
    localparam logic [RLOW_W-1:0] RLOW_LIMIT = RLOW_W'(RESET_MIN_CYCLES);

    // ------------------------------------------------------------
    // Flag layout
    // ------------------------------------------------------------
    localparam int FLAG_W     = 8;
    localparam int FLAG_READY = 0;
    localparam int FLAG_LOS   = 1;
    localparam int FLAG_TXF   = 2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic reset_low;
        logic select_low;
        logic low_power;
        logic scl;
        logic sda;
    } pins_type;

    typedef struct packed {
        logic              rd_done;
        logic [FLAG_W-1:0] rd_sel;
        logic              wr_done;
        logic [FLAG_W-1:0] wr_mask;
        logic              wr_pdown;
    } host_req_type;

    typedef enum logic {
        ST_INIT = 1'b0,
        ST_RUN  = 1'b1
    } run_state_type;

    typedef struct packed {
        logic [1:0]        rst_s;
        logic [1:0]        sel_s;
        logic [1:0]        lp_s;
        logic [1:0]        scl_s;
        logic [1:0]        sda_s;
        logic              scl_p;
        logic              sda_p;
        run_state_type     st;
        logic [RLOW_W-1:0] rlow_cnt;
        logic [INIT_W-1:0] init_cnt;
        logic              not_ready;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] mask;
        logic [FLAG_W-1:0] rd_pend;
        logic [FLAG_W-1:0] wr_mask;
        logic              wr_pend;
        logic              wr_pdown;
        logic              pdown;
        logic              stop_seen;
        logic              int_low;
        logic              respond;
        logic              low_power;
    } state_type;

    localparam state_type STATE_RESET = '{
        rst_s: 2'h3, sel_s: 2'h3, lp_s: 2'h0, scl_s: 2'h3, sda_s: 2'h3,
        scl_p: 1'b1, sda_p: 1'b1, st: ST_INIT, rlow_cnt: '0, init_cnt: '0,
        not_ready: 1'b1, flags: '0, mask: '0, rd_pend: '0, wr_mask: '0,
        wr_pend: 1'b0, wr_pdown: 1'b0, pdown: 1'b0, stop_seen: 1'b0,
        int_low: 1'b1, respond: 1'b0, low_power: 1'b0
    };

endpackage

/* test/host_ctrl.sv */
/*
 * Host board controller model: drives the module pins and frames a stop
 * followed by a bus clock fall on the two-wire bus.
 * Assumes a 250 MHz clk; pins change on its falling edge, bus clock 64 ns.
 */
`timescale 1ns/1ps
module host_ctrl (
    input  wire logic                          clk,
    output mgmt_supervisor_pkg::pins_type      pins
);
    import mgmt_supervisor_pkg::*;

    // Bus idles high by pull-up, bus clock stands still outside frames
    initial pins = '{reset_low: 1'b1, select_low: 1'b0, low_power: 1'b0,
                     scl: 1'b1, sda: 1'b1};

    task automatic half_bit();
        repeat (8) @(negedge clk);
    endtask

    task automatic pulse_reset(input int unsigned cycles);
        @(negedge clk);
        pins.reset_low = 1'b0;
        repeat (cycles) @(negedge clk);
        pins.reset_low = 1'b1;
    endtask

    task automatic set_pins(input logic sel_low, input logic lp);
        @(negedge clk);
        pins.select_low = sel_low;
        pins.low_power  = lp;
    endtask

    // Stop bit, then the falling bus clock edge that commits
    task automatic stop_commit();
        @(negedge clk);
        pins.scl = 1'b0;
        pins.sda = 1'b0;
        half_bit();
        pins.scl = 1'b1;
        half_bit();
        pins.sda = 1'b1;
        half_bit();
        pins.scl = 1'b0;
        half_bit();
        pins.scl = 1'b1;
    endtask
endmodule

/* test/tb.sv */
/*
 * Testbench for the management supervisor: start-up, flags, clear-on-read,
 * masking, select, low power and reset pin.
 * Assumes host_ctrl drives the pins; bus engine requests come from here.
 */
`timescale 1ns/1ps
module tb;
    import mgmt_supervisor_pkg::*;

    localparam int unsigned INIT_N = 50;

    logic              clk;
    logic              rst;
    pins_type          pins;
    host_req_type      req;
    logic [FLAG_W-1:0] flag_events;
    logic [FLAG_W-1:0] flag_status;
    logic [FLAG_W-1:0] mask_status;
    logic              interrupt_out_low;
    logic              bus_respond;
    logic              low_power_level;
    logic              data_not_ready;
    logic              pdown_status;
    int                fails;
    int                comparisons;

    host_ctrl i_host (.clk(clk), .pins(pins));

    mgmt_supervisor #(.INIT_CYCLES(INIT_N)) i_dut (
        .clk(clk), .rst(rst), .pins(pins), .req(req), .flag_events(flag_events),
        .interrupt_out_low(interrupt_out_low), .bus_respond(bus_respond),
        .low_power_level(low_power_level), .data_not_ready(data_not_ready),
        .flag_status(flag_status), .mask_status(mask_status),
        .pdown_status(pdown_status));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus engine requests
    // ------------------------------------------------------------
    task automatic read_clear(input logic [7:0] sel);
        @(negedge clk);
        req.rd_done = 1'b1;
        req.rd_sel  = sel;
        @(negedge clk);
        req.rd_done = 1'b0;
        repeat (4) @(negedge clk);
        check(flag_status & sel, sel);
        i_host.stop_commit();
        repeat (6) @(negedge clk);
    endtask

    task automatic write_ctrl(input logic [7:0] mask, input logic pd);
        @(negedge clk);
        req.wr_done  = 1'b1;
        req.wr_mask  = mask;
        req.wr_pdown = pd;
        @(negedge clk);
        req.wr_done = 1'b0;
        i_host.stop_commit();
        repeat (6) @(negedge clk);
        check(mask_status, mask);
    endtask

    task automatic raise_event(input logic [7:0] ev);
        @(negedge clk);
        flag_events = ev;
        @(negedge clk);
        flag_events = '0;
        repeat (4) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic start_up();
        repeat (INIT_N - 6) @(negedge clk);
        check(data_not_ready, 1'b1);
        check(interrupt_out_low, 1'b1);
        repeat (10) @(negedge clk);
        check(data_not_ready, 1'b0);
        check(flag_status, 8'h01);
        check(interrupt_out_low, 1'b0);
        check(bus_respond, 1'b1);
        read_clear(8'h01);
        check(flag_status, 8'h00);
        check(interrupt_out_low, 1'b1);
    endtask

    task automatic flag_loop();
        raise_event(8'h01);
        check(flag_status, 8'h00);
        for (int i = 1; i < FLAG_W; i++) begin
            raise_event(8'h01 << i);
            check(flag_status, 8'h01 << i);
            check(interrupt_out_low, 1'b0);
            read_clear(8'h01 << i);
            check(flag_status, 8'h00);
            check(interrupt_out_low, 1'b1);
        end
    endtask

    task automatic masking();
        write_ctrl(8'h04, 1'b0);
        raise_event(8'h04);
        check(flag_status, 8'h04);
        check(interrupt_out_low, 1'b1);
        write_ctrl(8'h00, 1'b0);
        check(interrupt_out_low, 1'b0);
        read_clear(8'h04);
        check(interrupt_out_low, 1'b1);
    endtask

    task automatic select_power();
        i_host.set_pins(1'b1, 1'b1);
        repeat (5) @(negedge clk);
        check(bus_respond, 1'b0);
        check(low_power_level, 1'b1);
        i_host.set_pins(1'b0, 1'b0);
        repeat (5) @(negedge clk);
        check(bus_respond, 1'b1);
        check(low_power_level, 1'b0);
        write_ctrl(8'h00, 1'b1);
        check({pdown_status, low_power_level}, 8'h03);
        write_ctrl(8'h00, 1'b0);
        check({pdown_status, low_power_level}, 8'h00);
    endtask

    task automatic reset_pin();
        write_ctrl(8'h02, 1'b0);
        i_host.pulse_reset(100);
        repeat (6) @(negedge clk);
        check(data_not_ready, 1'b0);
        check(mask_status, 8'h02);
        i_host.pulse_reset(600);
        check({data_not_ready, interrupt_out_low}, 8'h03);
        check(mask_status, 8'h00);
        raise_event(8'h02);
        check(flag_status, 8'h00);
        repeat (INIT_N + 10) @(negedge clk);
        check(data_not_ready, 1'b0);
        check(interrupt_out_low, 1'b0);
    endtask

    initial begin
        #50us;
        fails++;
        end_of_test();
    end

    initial begin
        fails       = 0;
        comparisons = 0;
        rst         = 1'b1;
        req         = '0;
        flag_events = '0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        start_up();
        flag_loop();
        masking();
        select_power();
        reset_pin();
        end_of_test();
    end
endmodule
